// *** pc_next.sv ***
// next program counter selection with wraparound to the implemented size
module pc_next
    import seq_pkg::*;
(
    input  wire addr_t       pc,
    input  wire addr_t       mask,
    input  pc_sel_e          sel,
    input  wire logic [8:0]  lit,
    input  wire logic [1:0]  page_select_bits,
    input  wire logic [7:0]  pc_low_byte,
    input  wire addr_t       stack_head_entry,
    output addr_t            pc_nxt
);

    // page bits come from the preselect on goto, call and low-byte write; increment keeps the pc's own, return takes the stack's
    always_comb begin
        case (sel)
            SEL_GOTO: pc_nxt = {page_select_bits, lit} & mask;
            SEL_CALL: pc_nxt = {page_select_bits, 1'b0, lit[7:0]} & mask;
            SEL_RET:  pc_nxt = stack_head_entry & mask;
            SEL_LOW:  pc_nxt = {page_select_bits, 1'b0, pc_low_byte} & mask;
            default:  pc_nxt = addr_t'(pc + 11'h001) & mask;
        endcase
    end

endmodule

// *** prog_file_model.sv ***
// program memory and register file behind the sequencer
module prog_file_model
    import seq_pkg::*;
(
    input  wire logic        clk,
    input  wire addr_t       pmem_addr,
    output logic [11:0]      pmem_rdata,
    input  file_req_s        file_req,
    output logic [7:0]       file_rdata
);
    logic [11:0] rom [0:2047];
    logic [7:0]  regs [0:31];

    // both reads are combinational, same cycle as the address
    assign pmem_rdata = rom[pmem_addr];
    assign file_rdata = regs[file_req.addr];

    // register file takes a write at the clock edge
    always @(posedge clk) begin
        if (file_req.we === 1'b1) begin
            regs[file_req.addr] <= file_req.wdata;
        end
    end
endmodule

// *** program_sequencer_stack.sv ***
// program sequencer with return stack, bit ops and an AXI4-Lite status port
module program_sequencer_stack
    import seq_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output addr_t                  pmem_addr,
    input  wire logic [11:0]       pmem_rdata,
    output file_req_s              file_req,
    input  wire logic [7:0]        file_rdata
);

    logic [1:0]  rst_sync_r;
    logic        rst_q;
    core_state_s s_r;
    core_state_s s_nxt;
    addr_t       mask;
    logic [4:0]  fx;
    logic [2:0]  bx;
    logic [7:0]  bit_onehot;
    logic [7:0]  rd_byte;
    logic [7:0]  set_val;
    logic [7:0]  low_src;
    logic        bit_val;
    logic        op_goto;
    logic        op_call;
    logic        op_ret;
    logic        bit_set_op;
    logic        skip_if_bit_clear_op;
    logic        op_movlw;
    logic        op_movwf;
    logic        pc_low_wr;
    logic        status_wr;
    logic        skip_taken;
    logic        flush;
    pc_sel_e     sel;
    addr_t       pc_calc;
    addr_t       stk_head;
    addr_t       stk_second;
    logic        do_write;
    logic [1:0]  w_resp;
    logic [1:0]  r_resp;

    // reset released through two flops, asserted at once
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_q = rst_sync_r[1];

    // one decoder for both channels: unmapped gets DECERR, read-only writes SLVERR
    function automatic logic [1:0] addr_resp(input logic [AXI_AW-1:0] a, input logic wr);
        if (a[1:0] != 2'h0 || a > REG_CORE) begin
            addr_resp = RESP_DECERR;
        end else if (wr && a != REG_CTRL) begin
            addr_resp = RESP_SLVERR;
        end else begin
            addr_resp = RESP_OKAY;
        end
    endfunction

    // memory size sets pc width: 9, 10 or 11 bits
    assign mask = size_mask(s_r.size);

    // instruction fields and decode of the word now executing
    assign fx         = s_r.ir[4:0];
    assign bx         = s_r.ir[7:5];
    assign bit_onehot = 8'h01 << bx;
    assign op_goto    = s_r.ir[11:9] == OP_GOTO;
    assign op_call    = s_r.ir[11:8] == OP_CALL;
    assign op_ret     = s_r.ir[11:8] == OP_RET_LIT;
    assign bit_set_op = s_r.ir[11:8] == OP_BIT_SET;
    assign skip_if_bit_clear_op = s_r.ir[11:8] == OP_SKIP_CLR;
    assign op_movlw   = s_r.ir[11:8] == OP_MOVLW;
    assign op_movwf   = s_r.ir[11:5] == OP_MOVWF;

    // pc low byte and status live here; other files come from outside
    always_comb begin
        if (fx == FILE_PC_LOW) begin
            rd_byte = pmem_addr[7:0];
        end else if (fx == FILE_STATUS) begin
            rd_byte = {1'b0, s_r.page, 5'h00};
        end else begin
            rd_byte = file_rdata;
        end
    end
    assign set_val    = rd_byte | bit_onehot;
    assign bit_val    = |(rd_byte & bit_onehot);
    assign pc_low_wr  = s_r.run && (op_movwf || bit_set_op) && fx == FILE_PC_LOW;
    assign status_wr  = s_r.run && (op_movwf || bit_set_op) && fx == FILE_STATUS;
    assign skip_taken = s_r.run && skip_if_bit_clear_op && !bit_val;
    // a bit set writes the read byte with its bit merged, a move writes the accumulator
    assign low_src    = bit_set_op ? set_val : s_r.acc;
    // any change of flow throws away the word fetched behind it
    assign flush      = op_goto || op_call || op_ret || pc_low_wr || skip_taken;

    // pick the source of the next fetch address
    always_comb begin
        if (op_goto) begin
            sel = SEL_GOTO;
        end else if (op_call) begin
            sel = SEL_CALL;
        end else if (op_ret) begin
            sel = SEL_RET;
        end else if (pc_low_wr) begin
            sel = SEL_LOW;
        end else begin
            sel = SEL_INC;
        end
    end

    pc_next u_pc_next (
        .pc               (s_r.pc),
        .mask             (mask),
        .sel              (sel),
        .lit              (s_r.ir[8:0]),
        .page_select_bits (s_r.page),
        .pc_low_byte      (low_src),
        .stack_head_entry (stk_head),
        .pc_nxt           (pc_calc)
    );

    // fetch address already points one past the executing word: that is the return
    return_stack u_stack (
        .clk              (clk),
        .rst_b            (rst_q),
        .push             (s_r.run && op_call),
        .pop              (s_r.run && op_ret),
        .push_addr        (s_r.pc),
        .stack_head_entry (stk_head),
        .stack_second     (stk_second)
    );

    // register file writes for bit set and move, except the two held here
    always_comb begin
        file_req.addr  = fx;
        file_req.wdata = low_src;
        file_req.we    = s_r.run && (bit_set_op || op_movwf)
                         && fx != FILE_PC_LOW && fx != FILE_STATUS;
    end

    assign do_write = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    assign w_resp   = addr_resp(s_r.awaddr, 1'b1);
    assign r_resp   = addr_resp(s_axi_araddr, 1'b0);

    // whole next state: core sequencing, then the bus slave
    always_comb begin
        s_nxt = s_r;
        if (!s_r.run) begin
            // halted core sits at the reset vector with page 0 preselected
            s_nxt.page = 2'h0;
            s_nxt.ir = OP_NOP;
        end else begin
            s_nxt.pc = pc_calc;
            s_nxt.ir = flush ? OP_NOP : pmem_rdata;
            if (op_ret || op_movlw) begin
                s_nxt.acc = s_r.ir[7:0];
            end
            if (status_wr) begin
                s_nxt.page = low_src[PAGE_LSB+:2];
            end
        end
        // write address and data are taken in either order
        if (s_axi_awvalid && !s_r.aw_have) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_have) begin
            s_nxt.w_have = 1'b1;
            s_nxt.wdata  = s_axi_wdata;
            s_nxt.wstrb  = s_axi_wstrb;
        end
        if (do_write) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = w_resp;
            if (w_resp == RESP_OKAY && s_r.wstrb[0]) begin
                s_nxt.run = s_r.wdata[CTRL_RUN_BIT];
                // size may only change while halted, so the pc never exceeds it
                if (!s_r.run) begin
                    s_nxt.size = s_r.wdata[CTRL_SIZE_LSB+:2];
                end
            end
        end else if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        // halted pc follows the size about to take effect, so it never sits past it
        if (!s_r.run) begin
            s_nxt.pc = size_mask(s_nxt.size);
        end
        // read answer one cycle after the address is taken
        if (s_axi_arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = r_resp;
            case (s_axi_araddr)
                REG_CTRL:  s_nxt.rdata = {29'h0, s_r.size, s_r.run};
                REG_PC:    s_nxt.rdata = {21'h0, s_r.pc};
                REG_STACK: s_nxt.rdata = {5'h0, stk_second, 5'h0, stk_head};
                REG_CORE:  s_nxt.rdata = {22'h0, s_r.page, s_r.acc};
                default:   s_nxt.rdata = 32'h0000_0000;
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // bus outputs; ready terms are combinational from held flags
    assign s_axi_awready = !s_r.aw_have;
    assign s_axi_wready  = !s_r.w_have;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign pmem_addr     = s_r.pc;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_q);

    sequence s_skip_taken;
        s_r.run && skip_if_bit_clear_op && !bit_val;
    endsequence

    sequence s_nop_runs;
        s_r.ir == OP_NOP;
    endsequence

    sequence s_start;
        !s_r.run ##1 s_r.run;
    endsequence

    sequence s_flow_change;
        s_r.run && (op_goto || op_call || op_ret || pc_low_wr);
    endsequence

    pc_in_range_a: assert property ((s_r.pc & ~mask) == 11'h000)
        else $error("pc beyond implemented memory");
    reset_vector_a: assert property (!s_r.run |=> !s_r.run || s_r.pc == mask)
        else $error("halted pc not at last location");
    first_fetch_a: assert property (s_start |-> s_r.pc == mask ##1 s_r.pc == 11'h000)
        else $error("start did not fetch reset vector then wrap to 000h");
    page_clear_a: assert property (s_start |-> s_r.page == 2'h0)
        else $error("page bits not cleared at start");
    page_carry_a: assert property (s_r.run && sel == SEL_INC && !status_wr
                                   |=> s_r.page == $past(s_r.page)
                                       && s_r.pc == (($past(s_r.pc) + 11'h001) & mask))
        else $error("increment broke carry or touched page bits");
    goto_page_a: assert property (s_r.run && op_goto
                                  |=> s_r.pc == ({$past(s_r.page), $past(s_r.ir[8:0])} & mask))
        else $error("jump target not from page bits");
    call_target_a: assert property (s_r.run && op_call
                                    |=> stk_head == $past(s_r.pc)
                                        && s_r.pc == ({$past(s_r.page), 1'b0, $past(s_r.ir[7:0])}
                                                      & mask))
        else $error("call pushed wrong return or wrong target");
    return_load_a: assert property (s_r.run && op_ret
                                    |=> s_r.pc == ($past(stk_head) & mask)
                                        && s_r.acc == $past(s_r.ir[7:0]))
        else $error("return lost pc or literal");
    bit_set_a: assert property (s_r.run && bit_set_op && fx > FILE_STATUS
                                |-> file_req.we && file_req.wdata[bx]
                                    && (file_req.wdata | bit_onehot) == (file_rdata | bit_onehot))
        else $error("bit set wrote wrong value");
    skip_flush_a: assert property (s_skip_taken |=> s_nop_runs)
        else $error("taken skip did not discard prefetch");
    no_skip_a: assert property (s_r.run && skip_if_bit_clear_op && bit_val
                                |=> s_r.ir == $past(pmem_rdata))
        else $error("skip taken with bit set");
    flow_flush_a: assert property (s_flow_change |=> s_nop_runs)
        else $error("change of flow kept the prefetched word");
    low_write_a: assert property (s_r.run && pc_low_wr
                                  |=> s_r.pc == ({$past(s_r.page), 1'b0, $past(low_src)} & mask))
        else $error("low byte write ignored the page bits");
    halt_page_a: assert property (!s_r.run |=> s_r.page == 2'h0)
        else $error("halted core kept a page preselect");
    set_no_flag_a: assert property (s_r.run && bit_set_op && fx != FILE_STATUS
                                    |=> s_r.page == $past(s_r.page))
        else $error("bit set touched the page bits");
    skip_no_flag_a: assert property (s_skip_taken |=> s_r.page == $past(s_r.page))
        else $error("skip touched the page bits");

    // bus answers stand until the master takes them
    write_answer_a: assert property (do_write |=> s_axi_bvalid)
        else $error("performed write gave no response");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
                                  |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
                                  |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before it was taken");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("new read accepted while an answer waits");

endmodule

// *** program_sequencer_stack_tb.sv ***
// self-checking bench for the program sequencer
module program_sequencer_stack_tb
    import seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_b, run_on;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [4:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, cur_sz;
    addr_t       pmem_addr;
    logic [11:0] pmem_rdata;
    file_req_s   file_req;
    logic [7:0]  file_rdata;
    int          fail_count, num_checks, cycles, seed;

    program_sequencer_stack program_sequencer_stack_i (
        .clk(clk), .rst_b(rst_b),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
        .file_req(file_req), .file_rdata(file_rdata)
    );

    prog_file_model prog_file_model_i (
        .clk(clk), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
        .file_req(file_req), .file_rdata(file_rdata)
    );

    // clock at 50 MHz
    always #10 clk = ~clk;

    // implemented size as an address mask, worked out independently
    function automatic addr_t mask_of(input logic [1:0] sz);
        mask_of = (sz == 2'h0) ? 11'h1ff : (sz == 2'h1) ? 11'h3ff : 11'h7ff;
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // address and data offered together, released each on its own take
    task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // nested calls, two returns, bit set and both skip outcomes, then a page loop
    task automatic run_prog(input logic [1:0] sz);
        addr_t      m, p;
        logic [7:0] lit;
        int         n;
        m = mask_of(sz);
        p = 11'h200 & m; // 512 size wraps page 1 onto page 0
        lit = 8'($random(seed));
        for (int i = 0; i < 2048; i++) prog_file_model_i.rom[i] = OP_NOP;
        for (int i = 0; i < 32; i++) prog_file_model_i.regs[i] = 8'h00;
        prog_file_model_i.rom[11'h000] = 12'hc20; // page bit value into accumulator
        prog_file_model_i.rom[11'h001] = 12'h023; // accumulator into status
        prog_file_model_i.rom[11'h002] = 12'h910;
        prog_file_model_i.rom[p | 11'h010] = 12'h920;
        prog_file_model_i.rom[p | 11'h020] = 12'h930;
        prog_file_model_i.rom[p | 11'h030] = 12'h8a5;
        prog_file_model_i.rom[p | 11'h021] = {4'h8, lit};
        prog_file_model_i.rom[p | 11'h011] = 12'h568;
        prog_file_model_i.rom[p | 11'h012] = 12'h668;
        prog_file_model_i.rom[p | 11'h013] = 12'h648;
        prog_file_model_i.rom[p | 11'h014] = 12'h509; // must be skipped
        prog_file_model_i.rom[p | 11'h015] = 12'h502; // bit set on the low byte jumps ahead
        prog_file_model_i.rom[p | 11'h017] = 12'ha17;
        cur_sz = sz;
        axi_write(REG_CTRL, {29'h0, sz, 1'b0}, rsp);
        check("ctrl_resp", 32'(rsp), 32'(RESP_OKAY));
        axi_read(REG_PC, rd, rsp);
        check("halt_pc", rd, 32'(m));
        axi_write(REG_CTRL, {29'h0, sz, 1'b1}, rsp);
        run_on = 1'b1;
        n = 0;
        do begin
            axi_read(REG_PC, rd, rsp);
            n++;
        end while (rd !== 32'(p | 11'h017) && n < 40);
        check("loop_pc", rd, 32'(p | 11'h017));
        axi_read(REG_STACK, rd, rsp);
        check("stack", rd, {5'h0, p | 11'h011, 5'h0, p | 11'h011});
        axi_read(REG_CORE, rd, rsp);
        check("core", rd, {22'h0, 2'h1, lit});
        check("bit_set", 32'(prog_file_model_i.regs[8]), 32'h08);
        check("skipped", 32'(prog_file_model_i.regs[9]), 32'h00);
        run_on = 1'b0;
        axi_write(REG_CTRL, {29'h0, sz, 1'b0}, rsp);
    endtask

    // hang guard and fetch-range watch while the core runs
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            fail_count++;
            end_of_test();
        end
        if (run_on) begin
            check("fetch_range", 32'(pmem_addr & ~mask_of(cur_sz)), 32'h0);
        end
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        run_on = 1'b0;
        cur_sz = 2'h2;
        seed = 57;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = 5'h00;
        s_axi_araddr = 5'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        axi_read(REG_CTRL, rd, rsp);
        check("ctrl_reset", rd, 32'h4);
        axi_read(REG_PC, rd, rsp);
        check("pc_reset", rd, 32'h7ff);
        axi_read(REG_CORE, rd, rsp);
        check("page_reset", rd, 32'h0);
        axi_read(5'h10, rd, rsp);
        check("unmapped", 32'(rsp), 32'(RESP_DECERR));
        axi_write(REG_PC, 32'h0, rsp);
        check("ro_write", 32'(rsp), 32'(RESP_SLVERR));
        // every size code in turn, 3 as the second 2K code; the 512 run also wraps
        for (int s = 0; s < 4; s++) run_prog(2'(s));
        end_of_test();
    end
endmodule

// *** return_stack.sv ***
// two-level hardware return stack
module return_stack
    import seq_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_b,
    input  wire logic  push,
    input  wire logic  pop,
    input  wire addr_t push_addr,
    output addr_t      stack_head_entry,
    output addr_t      stack_second
);

    stack_s st_r;
    stack_s st_nxt;

    // push shifts level 1 down, pop copies level 2 up and keeps level 2
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.lvl2 = st_r.lvl1;
            st_nxt.lvl1 = push_addr;
        end else if (pop) begin
            st_nxt.lvl1 = st_r.lvl2;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stack_head_entry = st_r.lvl1;
    assign stack_second     = st_r.lvl2;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_two_pushes;
        push ##1 !push && !pop ##1 push;
    endsequence

    push_order_a: assert property (push |=> st_r.lvl2 == $past(st_r.lvl1) && st_r.lvl1 == $past(push_addr))
        else $error("call did not shift the stack");
    oldest_lost_a: assert property (s_two_pushes |=> st_r.lvl2 == $past(push_addr, 3))
        else $error("deep calls kept a stale return address");
    pop_keep_a: assert property (pop && !push |=> $stable(st_r.lvl2) && st_r.lvl1 == $past(st_r.lvl2))
        else $error("return changed level 2 or missed the copy");

endmodule

// *** seq_pkg.sv ***
// shared constants, types and decode helpers for the program sequencer
package seq_pkg;

    // program counter and memory size selection
    localparam int           PC_W        = 11;
    typedef logic [PC_W-1:0] addr_t;
    localparam logic [1:0]   SIZE_512    = 2'h0;
    localparam logic [1:0]   SIZE_1K     = 2'h1;
    localparam logic [1:0]   SIZE_2K     = 2'h2;
    localparam logic [1:0]   SIZE_RESET  = SIZE_2K;
    localparam addr_t        MASK_512    = 11'h1ff;
    localparam addr_t        MASK_1K     = 11'h3ff;
    localparam addr_t        MASK_2K     = 11'h7ff;

    // instruction encodings
    localparam logic [11:0]  OP_NOP      = 12'h000;
    localparam logic [2:0]   OP_GOTO     = 3'h5;
    localparam logic [3:0]   OP_CALL     = 4'h9;
    localparam logic [3:0]   OP_RET_LIT  = 4'h8;
    localparam logic [3:0]   OP_BIT_SET  = 4'h5;
    localparam logic [3:0]   OP_SKIP_CLR = 4'h6;
    localparam logic [3:0]   OP_MOVLW    = 4'hc;
    localparam logic [6:0]   OP_MOVWF    = 7'h01;
    localparam logic [4:0]   FILE_PC_LOW = 5'h02;
    localparam logic [4:0]   FILE_STATUS = 5'h03;
    localparam int           PAGE_LSB    = 5;

    // register map, byte addresses
    localparam int           AXI_AW        = 5;
    localparam logic [4:0]   REG_CTRL      = 5'h00;
    localparam logic [4:0]   REG_PC        = 5'h04;
    localparam logic [4:0]   REG_STACK     = 5'h08;
    localparam logic [4:0]   REG_CORE      = 5'h0c;
    localparam int           CTRL_RUN_BIT  = 0;
    localparam int           CTRL_SIZE_LSB = 1;
    localparam int           STACK_L2_LSB  = 16;
    localparam int           CORE_PAGE_LSB = 8;
    localparam logic [1:0]   RESP_OKAY     = 2'h0;
    localparam logic [1:0]   RESP_SLVERR   = 2'h2;
    localparam logic [1:0]   RESP_DECERR   = 2'h3;

    typedef struct packed {
        logic       we;
        logic [4:0] addr;
        logic [7:0] wdata;
    } file_req_s;

    typedef enum logic [4:0] {
        SEL_INC  = 5'b00001,
        SEL_GOTO = 5'b00010,
        SEL_CALL = 5'b00100,
        SEL_RET  = 5'b01000,
        SEL_LOW  = 5'b10000
    } pc_sel_e;

    typedef struct packed {
        addr_t lvl1;
        addr_t lvl2;
    } stack_s;

    typedef struct packed {
        logic        run;
        logic [1:0]  size;
        addr_t       pc;
        logic [11:0] ir;
        logic [7:0]  acc;
        logic [1:0]  page;
        logic        aw_have;
        logic [4:0]  awaddr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } core_state_s;

    localparam core_state_s STATE_RESET = '{
        run: 1'b0, size: SIZE_RESET, pc: MASK_2K, ir: OP_NOP, acc: 8'h00, page: 2'h0,
        aw_have: 1'b0, awaddr: 5'h00, w_have: 1'b0, wdata: 32'h0000_0000, wstrb: 4'h0,
        bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: 32'h0000_0000,
        rresp: RESP_OKAY};

    // address mask of the implemented memory, also the last location
    function automatic addr_t size_mask(input logic [1:0] sz);
        case (sz)
            SIZE_512: size_mask = MASK_512;
            SIZE_1K:  size_mask = MASK_1K;
            default:  size_mask = MASK_2K;
        endcase
    endfunction

endpackage
